/* verilog/ssr_pkg.sv */
// Shared constants and helpers for the converter readout link
// What this block does
// - Convert-start rise samples data-in, picks mode
// - Data-in tied to convert-start gives chain
// - Optional busy start bit ahead of result
// - No busy: host waits maximum conversion time
// - Select mode busy if start/data-in low
// - Chain busy only if SCK high at start
// - Start with data-in high: select, float output
// - Conversion completes whatever convert-start does later
// - No busy: start line high through conversion
// - After conversion, acquire and power down
// - Start falling drives MSB, SCK falls shift
// - Float at start rise or 18th/19th edge
// - Bit holds across both SCK edges
// - Busy: start line low through conversion
// - Busy: float, then drive low at end in select mode, high in chain
// - After busy bit, MSB first per edge
// - Three-wire: data-in tied high by host
// - Four-wire: data-in is readback select
// - Host keeps output contention brief
// - Two's complement result, saturate at limits
// - Conversion needs no SCK activity
package ssr_pkg;

   localparam int          RES_W           = 18;
   localparam int          AIN_W           = 20;
   localparam int          CNT_W           = 5;
   localparam logic [17:0] CODE_POS_FS     = 18'h1ffff;
   localparam logic [17:0] CODE_NEG_FS     = 18'h20000;
   localparam logic [4:0]  EDGES_NO_BUSY   = 5'h12;
   localparam logic [4:0]  EDGES_BUSY      = 5'h13;
   localparam logic [4:0]  EDGE_CNT_SAT    = 5'h1f;
   localparam int          CORE_MHZ        = 20;
   localparam int          CONV_MIN_NS     = 1000;
   localparam int          CONV_MAX_NS     = 2000;
   // Least time rounds up, longest time rounds down
   localparam int          CONV_MIN_CYC    = (CONV_MIN_NS * CORE_MHZ + 999) / 1000;
   localparam int          CONV_MAX_CYC    = (CONV_MAX_NS * CORE_MHZ) / 1000;
   localparam int          SYNC_MARGIN_CYC = 4;
   localparam int          SCK_HALF_CYC    = 6;
   localparam int          CNV_PULSE_CYC   = 4;
   localparam int          TCNT_W          = 16;

   function automatic logic [CNT_W-1:0] ssr_bin2gray(input logic [CNT_W-1:0] b);
      return b ^ (b >> 1);
   endfunction : ssr_bin2gray

   function automatic logic [CNT_W-1:0] ssr_gray2bin(input logic [CNT_W-1:0] g);
      logic [CNT_W-1:0] b;
      b[CNT_W-1] = g[CNT_W-1];
      for (int i = CNT_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : ssr_gray2bin

endpackage : ssr_pkg

/* verilog/ssr_link_if.sv */
// Serial link between the converter and its host, with pulled-up data-out
`timescale 1ns/1ns
interface ssr_link_if;
   logic convert_start;
   logic serial_data_in;
   logic sck;
   logic sdo_out;
   logic sdo_oe;
   logic serial_data_out;

   // Pull-up on the data-out line when nobody drives it
   assign serial_data_out = sdo_oe ? sdo_out : 1'b1;

   modport dev (
      input  convert_start,
      input  serial_data_in,
      input  sck,
      output sdo_out,
      output sdo_oe
   );

   modport host (
      output convert_start,
      output serial_data_in,
      output sck,
      input  serial_data_out
   );
endinterface : ssr_link_if

/* verilog/ssr_sync.sv */
// Two-stage synchroniser for levels and gray-coded words
`timescale 1ns/1ns
module ssr_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         i_clk,
   input  wire logic         i_rstn,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_q <= RST;
         o_q    <= RST;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule : ssr_sync

/* verilog/ssr_adc_dev.sv */
// Converter end: mode select, conversion timing and serial readout
`timescale 1ns/1ns
module ssr_adc_dev
   import ssr_pkg::*;
#(
   parameter int CONV_CYC = CONV_MAX_CYC
) (
   input  wire logic                    i_core_clk,
   input  wire logic                    i_rstn,
   ssr_link_if.dev                      link,
   input  wire logic signed [AIN_W-1:0] i_ain,
   output logic                         o_powered_down,
   output logic                         o_cs_mode,
   output logic                         o_busy_en,
   output logic             [RES_W-1:0] o_result
);

   typedef enum logic [1:0] {
      CV_ACQ  = 2'b01,
      CV_CONV = 2'b10
   } ssr_cv_e;

   typedef enum logic [2:0] {
      RD_IDLE  = 3'b001,
      RD_ARM   = 3'b010,
      RD_SHIFT = 3'b100
   } ssr_rd_e;

   localparam logic [TCNT_W-1:0] CONV_LAST = TCNT_W'(CONV_CYC - 1);
   localparam logic signed [AIN_W-1:0] AIN_HI = AIN_W'($signed({1'b0, CODE_POS_FS}));
   localparam logic signed [AIN_W-1:0] AIN_LO = AIN_W'($signed(CODE_NEG_FS));

   logic [2:0]              pin_s;
   logic                    cnv_s;
   logic                    sdi_s;
   logic                    sck_s;
   logic                    cnv_d1_q;
   logic                    sdi_d1_q;
   logic                    cnv_rise;
   ssr_cv_e                 cv_q;
   logic [TCNT_W-1:0]       conv_cnt_q;
   logic                    conv_end;
   logic signed [AIN_W-1:0] sample_q;
   logic [RES_W-1:0]        result_q;
   logic                    cs_mode_q;
   logic                    chain_busy_q;
   logic                    busy_q;
   logic                    busy_now;
   logic                    pd_q;
   ssr_rd_e                 rd_q;
   logic                    edge_clr_q;
   logic [CNT_W-1:0]        edge_cnt_q;
   logic [CNT_W-1:0]        edge_gray_q;
   logic [CNT_W-1:0]        edge_gray_s;
   logic [CNT_W-1:0]        edges;
   logic [CNT_W-1:0]        last_edge;
   logic [CNT_W-1:0]        bit_idx;
   logic                    sdo_q;
   logic                    sdo_oe_q;

   // Pins come from the host's domain
   ssr_sync #(
      .W   (3),
      .RST (3'h0)
   ) u_pin_sync (
      .i_clk  (i_core_clk),
      .i_rstn (i_rstn),
      .i_d    ({link.convert_start, link.serial_data_in, link.sck}),
      .o_q    (pin_s)
   );

   assign cnv_s = pin_s[2];
   assign sdi_s = pin_s[1];
   assign sck_s = pin_s[0];

   // Edge count from the link domain, gray coded so one bit moves at a time
   ssr_sync #(
      .W   (CNT_W),
      .RST ('0)
   ) u_edge_sync (
      .i_clk  (i_core_clk),
      .i_rstn (i_rstn),
      .i_d    (edge_gray_q),
      .o_q    (edge_gray_s)
   );

   assign edges     = ssr_gray2bin(edge_gray_s);
   assign last_edge = busy_q ? EDGES_BUSY : EDGES_NO_BUSY;
   // Busy bit occupies the first slot, data shifts one place later
   assign bit_idx   = CNT_W'(RES_W - 1) - edges + {{(CNT_W-1){1'b0}}, busy_q};

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnv_d1_q <= 1'b0;
         sdi_d1_q <= 1'b0;
      end else begin
         cnv_d1_q <= cnv_s;
         sdi_d1_q <= sdi_s;
      end
   end

   assign cnv_rise = cnv_s & ~cnv_d1_q;

   // Conversion sequencer on the internal clock; SCK plays no part
   // no SCK needed
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cv_q       <= CV_ACQ;
         conv_cnt_q <= '0;
         pd_q       <= 1'b1;
      end else begin
         case (cv_q)
            CV_ACQ: begin
               if (cnv_rise) begin
                  cv_q       <= CV_CONV;
                  conv_cnt_q <= '0;
                  pd_q       <= 1'b0;
               end
            end
            CV_CONV: begin
               conv_cnt_q <= conv_cnt_q + TCNT_W'(1);
               if (conv_cnt_q == CONV_LAST) begin
                  cv_q <= CV_ACQ;
                  pd_q <= 1'b1;
               end
            end
            default: begin
               cv_q <= CV_ACQ;
               pd_q <= 1'b1;
            end
         endcase
      end
   end

   assign conv_end = (cv_q == CV_CONV) && (conv_cnt_q == CONV_LAST);

   // Mode and sample captured at the start edge
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cs_mode_q    <= 1'b1;
         chain_busy_q <= 1'b0;
         sample_q     <= '0;
      end else if (cv_q == CV_ACQ && cnv_rise) begin
         // level held from before the edge, so a tied pair gives chain
         cs_mode_q    <= sdi_d1_q;
         chain_busy_q <= sck_s;
         sample_q     <= i_ain;
      end
   end

   // select-mode busy test at conversion end
   assign busy_now = cs_mode_q ? (~cnv_s | ~sdi_s) : chain_busy_q;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         result_q <= '0;
         busy_q   <= 1'b0;
      end else if (conv_end) begin
         if (sample_q > AIN_HI) begin
            result_q <= CODE_POS_FS;
         end else if (sample_q < AIN_LO) begin
            result_q <= CODE_NEG_FS;
         end else begin
            result_q <= sample_q[RES_W-1:0];
         end
         busy_q <= busy_now;
      end
   end

   // Readout sequencer; edge counter held clear whenever not shifting
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rd_q       <= RD_IDLE;
         edge_clr_q <= 1'b1;
      end else if (cv_q == CV_ACQ && cnv_rise) begin
         rd_q       <= RD_IDLE;
         edge_clr_q <= 1'b1;
      end else begin
         case (rd_q)
            RD_IDLE: begin
               if (conv_end) begin
                  if (busy_now || !cs_mode_q) begin
                     rd_q       <= RD_SHIFT;
                     edge_clr_q <= 1'b0;
                  end else begin
                     rd_q <= RD_ARM;
                  end
               end
            end
            RD_ARM: begin
               if (!cnv_s || !sdi_s) begin
                  rd_q       <= RD_SHIFT;
                  edge_clr_q <= 1'b0;
               end
            end
            RD_SHIFT: begin
               if (edges >= last_edge || (cs_mode_q && sdi_s && !sdi_d1_q)) begin
                  rd_q       <= RD_IDLE;
                  edge_clr_q <= 1'b1;
               end
            end
            default: begin
               rd_q       <= RD_IDLE;
               edge_clr_q <= 1'b1;
            end
         endcase
      end
   end

   // Link domain: counts SCK falling edges; frames end by the core's clear
   // each SCK fall advances
   always_ff @(negedge link.sck or posedge edge_clr_q) begin
      if (edge_clr_q) begin
         edge_cnt_q  <= '0;
         edge_gray_q <= '0;
      end else if (edge_cnt_q != EDGE_CNT_SAT) begin
         edge_cnt_q  <= edge_cnt_q + CNT_W'(1);
         edge_gray_q <= ssr_bin2gray(edge_cnt_q + CNT_W'(1));
      end
   end

   // Output pin: a bit changes only after a falling edge, so it spans both edges
   // bit stable across edges
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sdo_oe_q <= 1'b0;
         sdo_q    <= 1'b0;
      end else begin
         sdo_oe_q <= (rd_q == RD_SHIFT) && (edges < last_edge) && !cnv_rise;
         if (busy_q && edges == '0) begin
            // busy bit low in select mode, high in chain
            sdo_q <= ~cs_mode_q;
         end else if (bit_idx < CNT_W'(RES_W)) begin
            sdo_q <= result_q[bit_idx];
         end else begin
            sdo_q <= 1'b0;
         end
      end
   end

   assign link.sdo_out   = sdo_q;
   assign link.sdo_oe    = sdo_oe_q;
   assign o_powered_down = pd_q;
   assign o_cs_mode      = cs_mode_q;
   assign o_busy_en      = busy_q;
   assign o_result       = result_q;

endmodule : ssr_adc_dev

/* verilog/ssr_host.sv */
// Host end: starts conversions, makes SCK and reads the result
`timescale 1ns/1ns
module ssr_host
   import ssr_pkg::*;
#(
   parameter int SCK_HALF  = SCK_HALF_CYC,
   parameter int WAIT_CYC  = CONV_MAX_CYC + SYNC_MARGIN_CYC,
   parameter int CNV_PULSE = CNV_PULSE_CYC
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rstn,
   ssr_link_if.host              link,
   input  wire logic             i_start,
   input  wire logic             i_use_busy,
   output logic                  o_ready,
   output logic [RES_W-1:0]      o_data,
   output logic                  o_data_valid
);

   typedef enum logic [5:0] {
      H_IDLE  = 6'b000001,
      H_CNV   = 6'b000010,
      H_BUSYW = 6'b000100,
      H_LOW   = 6'b001000,
      H_HIGH  = 6'b010000,
      H_DONE  = 6'b100000
   } ssr_host_e;

   localparam logic [TCNT_W-1:0] HALF_LAST  = TCNT_W'(SCK_HALF - 1);
   localparam logic [TCNT_W-1:0] WAIT_LAST  = TCNT_W'(WAIT_CYC - 1);
   localparam logic [TCNT_W-1:0] PULSE_LAST = TCNT_W'(CNV_PULSE - 1);

   ssr_host_e         st_q;
   logic [TCNT_W-1:0] cnt_q;
   logic [CNT_W-1:0]  bit_q;
   logic [RES_W:0]    shreg_q;
   logic              busy_mode_q;
   logic              cnv_q;
   logic              sck_q;
   logic              sdi_q;
   logic              ready_q;
   logic              valid_q;
   logic [RES_W-1:0]  data_q;
   logic              sdo_s;
   logic [CNT_W-1:0]  last_bit;

   ssr_sync #(
      .W   (1),
      .RST (1'b1)
   ) u_sdo_sync (
      .i_clk  (i_core_clk),
      .i_rstn (i_rstn),
      .i_d    (link.serial_data_out),
      .o_q    (sdo_s)
   );

   assign last_bit = (busy_mode_q ? EDGES_BUSY : EDGES_NO_BUSY) - CNT_W'(1);

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sdi_q <= 1'b0;
      end else begin
         sdi_q <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q        <= H_IDLE;
         cnt_q       <= '0;
         bit_q       <= '0;
         shreg_q     <= '0;
         busy_mode_q <= 1'b0;
         cnv_q       <= 1'b0;
         sck_q       <= 1'b0;
         ready_q     <= 1'b0;
         valid_q     <= 1'b0;
         data_q      <= '0;
      end else begin
         valid_q <= 1'b0;
         case (st_q)
            H_IDLE: begin
               ready_q <= 1'b1;
               sck_q   <= 1'b0;
               if (i_start) begin
                  busy_mode_q <= i_use_busy;
                  cnv_q       <= 1'b1;
                  cnt_q       <= '0;
                  bit_q       <= '0;
                  ready_q     <= 1'b0;
                  st_q        <= H_CNV;
               end
            end
            H_CNV: begin
               cnt_q <= cnt_q + TCNT_W'(1);
               if (busy_mode_q && cnt_q == PULSE_LAST) begin
                  cnv_q <= 1'b0;
                  st_q  <= H_BUSYW;
               end else if (!busy_mode_q && cnt_q == WAIT_LAST) begin
                  cnv_q <= 1'b0;
                  cnt_q <= '0;
                  st_q  <= H_LOW;
               end
            end
            H_BUSYW: begin
               // Pulled-up line falling marks the end of conversion
               if (!sdo_s) begin
                  cnt_q <= '0;
                  st_q  <= H_LOW;
               end
            end
            H_LOW: begin
               cnt_q <= cnt_q + TCNT_W'(1);
               if (cnt_q == HALF_LAST) begin
                  sck_q <= 1'b1;
                  cnt_q <= '0;
                  st_q  <= H_HIGH;
               end
            end
            H_HIGH: begin
               cnt_q <= cnt_q + TCNT_W'(1);
               if (cnt_q == HALF_LAST) begin
                  // capture late in high phase, just before the fall
                  shreg_q <= {shreg_q[RES_W-1:0], sdo_s};
                  sck_q   <= 1'b0;
                  cnt_q   <= '0;
                  bit_q   <= bit_q + CNT_W'(1);
                  st_q    <= (bit_q == last_bit) ? H_DONE : H_LOW;
               end
            end
            H_DONE: begin
               // Busy bit ends in the top bit, data sits low in both modes
               data_q  <= shreg_q[RES_W-1:0];
               valid_q <= 1'b1;
               st_q    <= H_IDLE;
            end
            default: begin
               st_q  <= H_IDLE;
               cnv_q <= 1'b0;
               sck_q <= 1'b0;
            end
         endcase
      end
   end

   assign link.convert_start  = cnv_q;
   assign link.serial_data_in = sdi_q;
   assign link.sck            = sck_q;
   assign o_ready             = ready_q;
   assign o_data              = data_q;
   assign o_data_valid        = valid_q;

endmodule : ssr_host

/* sim/ssr_link_checker.sv */
// Assertions on the converter link, watching the interface lines
`timescale 1ns/1ns
module ssr_link_checker
   import ssr_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic convert_start,
   input wire logic serial_data_in,
   input wire logic sck,
   input wire logic sdo_out,
   input wire logic sdo_oe,
   input wire logic serial_data_out
);
   logic [7:0] low_cnt_q;
   logic [7:0] hi_cnt_q;
   logic [4:0] fall_cnt_q;
   logic       busy_q;
   logic [4:0] lim;

   assign lim = busy_q ? EDGES_BUSY : EDGES_NO_BUSY;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         low_cnt_q <= 8'h00;
      end else if (convert_start) begin
         low_cnt_q <= 8'h00;
      end else if (low_cnt_q != 8'hff) begin
         low_cnt_q <= low_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         hi_cnt_q <= 8'h00;
      end else if (!convert_start) begin
         hi_cnt_q <= 8'h00;
      end else if (hi_cnt_q != 8'hff) begin
         hi_cnt_q <= hi_cnt_q + 8'h01;
      end
   end

   // Busy flow told apart by how long the start line sat low
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy_q <= 1'b0;
      end else if (!sdo_oe) begin
         busy_q <= (low_cnt_q > 8'h0a);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         fall_cnt_q <= 5'h00;
      end else if (!sdo_oe) begin
         fall_cnt_q <= 5'h00;
      end else if ($fell(sck) && fall_cnt_q != 5'h1f) begin
         fall_cnt_q <= fall_cnt_q + 5'h01;
      end
   end

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rstn);

   sequence s_start;
      $rose(convert_start);
   endsequence
   sequence s_float_hold;
      !sdo_oe [*8];
   endsequence
   sequence s_bit_hold;
      $stable(sdo_out) [*6];
   endsequence

   float_after_start_a : assert property (s_start |=> ##4 s_float_hold)
      else $error("data-out driven early in conversion");
   conv_ends_a : assert property (s_start |-> ##[1:60] sdo_oe)
      else $error("conversion never reached readout");
   oe_when_low_a : assert property ($rose(sdo_oe) |-> !convert_start)
      else $error("data-out driven while start line high");
   busy_low_a : assert property ($rose(sdo_oe) && busy_q |-> !sdo_out)
      else $error("busy bit not low");
   msb_on_fall_a : assert property ($fell(convert_start) && hi_cnt_q > 8'h14 |-> ##[1:6] sdo_oe)
      else $error("no data after start line fell");
   bit_stable_a : assert property ($rose(sck) && sdo_oe |=> s_bit_hold)
      else $error("data bit moved while clock high");
   edge_limit_a : assert property (sdo_oe |-> fall_cnt_q <= lim)
      else $error("data-out driven past last edge");
   float_at_last_a : assert property (sdo_oe && fall_cnt_q == lim |-> ##[1:6] !sdo_oe)
      else $error("data-out not released after last edge");
   sdi_tied_a : assert property ($rose(convert_start) |-> serial_data_in)
      else $error("data-in low at conversion start");
   busy_edge_a : assert property ($rose(sdo_oe) && busy_q |-> $fell(serial_data_out))
      else $error("no falling edge on pulled-up line at busy");
endmodule : ssr_link_checker

/* sim/sar_adc_serial_readout_test.sv */
// Bench: host and converter joined, plus a second converter driven by hand
`timescale 1ns/1ns
module sar_adc_serial_readout_test;
   import ssr_pkg::*;
   localparam int           CYC_LIMIT = 8000;
   logic                    clk;
   logic                    rstn;
   logic                    i_start;
   logic                    i_use_busy;
   logic signed [AIN_W-1:0] i_ain;
   logic signed [AIN_W-1:0] ain_b;
   logic                    ready, data_valid, pd, cs_mode, busy_en, cs_b, busy_b;
   logic        [RES_W-1:0] data, result;
   int                      num_errors, n_checks;
   int                      cyc_cnt = 0;

   ssr_link_if u_link ();
   ssr_link_if u_link_b ();
   ssr_adc_dev u_ssr_adc_dev (.i_core_clk(clk), .i_rstn(rstn), .link(u_link.dev),
      .i_ain(i_ain), .o_powered_down(pd), .o_cs_mode(cs_mode), .o_busy_en(busy_en),
      .o_result(result));
   ssr_host u_ssr_host (.i_core_clk(clk), .i_rstn(rstn), .link(u_link.host),
      .i_start(i_start), .i_use_busy(i_use_busy), .o_ready(ready), .o_data(data),
      .o_data_valid(data_valid));
   ssr_adc_dev u_ssr_adc_dev_b (.i_core_clk(clk), .i_rstn(rstn), .link(u_link_b.dev),
      .i_ain(ain_b), .o_powered_down(), .o_cs_mode(cs_b), .o_busy_en(busy_b), .o_result());
   ssr_link_checker u_ssr_link_checker (.i_core_clk(clk), .i_rstn(rstn),
      .convert_start(u_link.convert_start), .serial_data_in(u_link.serial_data_in),
      .sck(u_link.sck), .sdo_out(u_link.sdo_out), .sdo_oe(u_link.sdo_oe),
      .serial_data_out(u_link.serial_data_out));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input string name, input logic [RES_W-1:0] seen,
                      input logic [RES_W-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   task automatic drive_b(input logic cs, input logic di, input logic sc, input int n);
      @(posedge clk);
      u_link_b.convert_start  <= cs;
      u_link_b.serial_data_in <= di;
      u_link_b.sck            <= sc;
      repeat (n) @(negedge clk);
   endtask : drive_b

   // Boundaries of the code range, alternating busy and plain reads
   task automatic t_select_reads();
      logic [19:0] ain_tab [6] = '{20'h12345, 20'hffffb, 20'h1ffff, 20'h20000, 20'hdffff,
                                   20'he0000};
      logic [17:0] exp_tab [6] = '{18'h12345, 18'h3fffb, 18'h1ffff, 18'h1ffff, 18'h20000,
                                   18'h20000};
      int          n;
      for (int i = 0; i < 6; i++) begin
         n = 0;
         while (ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
         end
         @(posedge clk);
         i_ain      <= ain_tab[i];
         i_use_busy <= i[0];
         i_start    <= 1'b1;
         @(posedge clk);
         i_start <= 1'b0;
         repeat (12) @(negedge clk);
         chk("converting", pd, 1'b0);
         n = 0;
         while (data_valid !== 1'b1 && n < 1500) begin
            @(negedge clk);
            n++;
         end
         chk("valid_seen", data_valid, 1'b1);
         chk("read_data", data, exp_tab[i]);
         chk("result", result, exp_tab[i]);
         chk("busy_en", busy_en, i[0]);
         chk("cs_mode", cs_mode, 1'b1);
         repeat (8) @(negedge clk);
         chk("released", u_link.sdo_oe, 1'b0);
         chk("powered_down", pd, 1'b1);
      end
   endtask : t_select_reads

   task automatic t_chain_modes();
      drive_b(1'b0, 1'b0, 1'b0, 4);
      drive_b(1'b1, 1'b0, 1'b0, 6);
      chk("chain_mode", cs_b, 1'b0);
      repeat (50) @(negedge clk);
      chk("chain_busy_off", busy_b, 1'b0);
      chk("chain_msb", {u_link_b.sdo_oe, u_link_b.serial_data_out}, 2'b11);
      drive_b(1'b0, 1'b0, 1'b0, 4);
      drive_b(1'b1, 1'b1, 1'b1, 6);
      chk("tied_mode", cs_b, 1'b0);
      chk("rise_float", u_link_b.sdo_oe, 1'b0);
      repeat (50) @(negedge clk);
      chk("chain_busy_on", busy_b, 1'b1);
      chk("busy_bit", {u_link_b.sdo_oe, u_link_b.sdo_out}, 2'b11);
      drive_b(1'b0, 1'b1, 1'b0, 4);
   endtask : t_chain_modes

   // Plain select read cut short by a new start
   task automatic t_select_abort();
      drive_b(1'b1, 1'b1, 1'b0, 6);
      chk("sel_mode", cs_b, 1'b1);
      chk("sel_float", u_link_b.sdo_oe, 1'b0);
      repeat (50) @(negedge clk);
      chk("sel_wait", u_link_b.sdo_oe, 1'b0);
      chk("sel_busy_off", busy_b, 1'b0);
      drive_b(1'b0, 1'b1, 1'b0, 6);
      chk("sel_msb", {u_link_b.sdo_oe, u_link_b.serial_data_out}, 2'b11);
      drive_b(1'b0, 1'b1, 1'b1, 6);
      chk("bit_at_rise", {u_link_b.sdo_oe, u_link_b.serial_data_out}, 2'b11);
      drive_b(1'b0, 1'b1, 1'b0, 8);
      chk("second_bit", {u_link_b.sdo_oe, u_link_b.serial_data_out}, 2'b10);
      drive_b(1'b1, 1'b1, 1'b0, 6);
      chk("abort_float", u_link_b.sdo_oe, 1'b0);
   endtask : t_select_abort

   // Four-wire read: start line stays high, data-in selects and releases
   task automatic t_four_wire();
      repeat (50) @(negedge clk);
      chk("fw_wait", u_link_b.sdo_oe, 1'b0);
      drive_b(1'b1, 1'b0, 1'b0, 6);
      chk("fw_msb", {u_link_b.sdo_oe, u_link_b.serial_data_out}, 2'b11);
      drive_b(1'b1, 1'b1, 1'b0, 6);
      chk("fw_release", u_link_b.sdo_oe, 1'b0);
   endtask : t_four_wire

   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == CYC_LIMIT) begin
         num_errors++;
         stop_test();
      end
   end

   initial begin
      num_errors              = 0;
      n_checks                = 0;
      rstn                    = 1'b0;
      i_start                 = 1'b0;
      i_use_busy              = 1'b0;
      i_ain                   = 20'h00000;
      ain_b                   = 20'hea5a5;
      u_link_b.convert_start  = 1'b0;
      u_link_b.serial_data_in = 1'b0;
      u_link_b.sck            = 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_select_reads();
      t_chain_modes();
      t_select_abort();
      t_four_wire();
      stop_test();
   end
endmodule : sar_adc_serial_readout_test
